// ==== logic/matg_pkg.sv ====
package matg_pkg;

    // ------------------------------------------------------------------
    // Clock rates
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ  = 20_000_000;
    localparam int unsigned LS_HZ   = 32_768;
    localparam int          ACC_W   = 25;
    // Phase step and modulus of the low-speed tick accumulator
    localparam logic [ACC_W-1:0] LS_STEP = ACC_W'(LS_HZ);
    localparam logic [ACC_W-1:0] LS_MOD  = ACC_W'(CLK_HZ);

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [13:0] IDX_ALARM_PATTERN  = 14'h1330;
    localparam logic [13:0] IDX_TONE_CONTROL   = 14'h1331;
    localparam logic [13:0] IDX_DIVISOR_LOW    = 14'h1332;
    localparam logic [13:0] IDX_DIVISOR_HIGH   = 14'h1333;
    localparam logic [13:0] IDX_RATE_IRQ_EN    = 14'h1334;
    localparam logic [13:0] IDX_RATE_IRQ_STAT  = 14'h1335;

    // ------------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_RESET       = 8'h00;
    localparam int         TC_SEL_BIT      = 0;
    localparam int         TC_INV_BIT      = 5;
    localparam int         TC_FC_LSB       = 6;
    localparam int         MH_RUN_BIT      = 7;
    localparam int         DIV_W           = 12;
    localparam int         FR_W            = 15;
    localparam int         RATE_N          = 5;
    localparam int         CARRIER_BIT     = 2;
    localparam int         SLOT_LSB        = 12;

    // Free-run counter control codes
    localparam logic [1:0] FC_HOLD         = 2'h0;
    localparam logic [1:0] FC_RESTART      = 2'h1;
    localparam logic [1:0] FC_CLEAR        = 2'h2;
    localparam logic [1:0] FC_CLEAR_START  = 2'h3;

    // Low bits that must all be one for each rate tick:
    // 1 Hz, 2 Hz, 64 Hz, 512 Hz, 8192 Hz
    localparam int RATE_W [RATE_N] = '{15, 14, 9, 6, 2};

    // Free-run counter states
    typedef enum logic [1:0] {
        MATG_FR_HOLD = 2'b01,
        MATG_FR_RUN  = 2'b10
    } matg_fr_state_e;

endpackage

// ==== logic/matg_melody.sv ====
`timescale 1ns/1ps
module matg_melody #(
    parameter int DIV_W = matg_pkg::DIV_W
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             ls_tick,
    input  wire logic             run,
    input  wire logic [DIV_W-1:0] divisor,
    output logic                  wave_reg
);

    logic [DIV_W:0] cnt_reg;
    logic [DIV_W:0] half_term;
    logic           at_term;

    // Half period is N+2 ticks, so a full period is 2N+4 ticks
    assign half_term = {1'b0, divisor} + {{DIV_W{1'b0}}, 1'b1};
    // At or past the end, so a divisor lowered mid-count cannot overrun
    assign at_term   = (cnt_reg >= half_term);

    // Stopping clears both the count and the output level
    always_ff @(posedge core_clk) begin
        if (rst || !run) begin
            cnt_reg  <= '0;
            wave_reg <= 1'b0;
        end else if (ls_tick) begin
            if (at_term) begin
                cnt_reg  <= '0;
                wave_reg <= ~wave_reg;
            end else begin
                cnt_reg  <= cnt_reg + {{DIV_W{1'b0}}, 1'b1};
            end
        end
    end

endmodule

// ==== logic/matg_freerun.sv ====
`timescale 1ns/1ps
module matg_freerun #(
    parameter int FR_W   = matg_pkg::FR_W,
    parameter int RATE_N = matg_pkg::RATE_N
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              ls_tick,
    input  wire logic              fc_write,
    input  wire logic [1:0]        fc_code,
    output logic [FR_W-1:0]        count_reg,
    output logic [RATE_N-1:0]      rate_tick_reg,
    output logic                   running
);

    matg_pkg::matg_fr_state_e state_reg;
    logic                     count_en;
    logic [RATE_N-1:0]        rate_next;

    assign running  = (state_reg == matg_pkg::MATG_FR_RUN);
    assign count_en = running & ls_tick & ~fc_write;

    // Each rate fires as its low bits roll over
    generate
        for (genvar i = 0; i < RATE_N; i++) begin : g_rate
            assign rate_next[i] = count_en &
                (&count_reg[matg_pkg::RATE_W[i]-1:0]);
        end
    endgenerate

    // A control write wins over a tick in the same cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg     <= matg_pkg::MATG_FR_HOLD;
            count_reg     <= '0;
            rate_tick_reg <= '0;
        end else begin
            rate_tick_reg <= rate_next;
            if (fc_write) begin
                case (fc_code)
                    matg_pkg::FC_HOLD: begin
                        state_reg <= matg_pkg::MATG_FR_HOLD;
                    end
                    matg_pkg::FC_RESTART: begin
                        state_reg <= matg_pkg::MATG_FR_RUN;
                    end
                    matg_pkg::FC_CLEAR: begin
                        state_reg <= matg_pkg::MATG_FR_HOLD;
                        count_reg <= '0;
                    end
                    default: begin
                        state_reg <= matg_pkg::MATG_FR_RUN;
                        count_reg <= '0;
                    end
                endcase
            end else if (count_en) begin
                count_reg <= count_reg + {{(FR_W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule

// ==== logic/matg_top.sv ====
`timescale 1ns/1ps
module matg_top (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [15:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             tone_output_pin,
    output logic             irq
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam int RN = matg_pkg::RATE_N;

    logic [7:0]                 alarm_pattern_reg;
    logic                       output_source_select_reg;
    logic                       alarm_invert_reg;
    logic [7:0]                 melody_divisor_low_reg;
    logic [7:0]                 melody_divisor_high_reg;
    logic [RN-1:0]              rate_interrupt_enable_reg;
    logic [RN-1:0]              rate_status_reg;
    logic [RN-1:0]              rate_status_next;
    logic                       ack_reg;
    logic [31:0]                readdata_reg;
    logic [31:0]                readdata_next;
    logic [matg_pkg::ACC_W-1:0] acc_reg;
    logic [matg_pkg::ACC_W-1:0] acc_sum;
    logic                       ls_tick_reg;
    logic                       tone_reg;
    logic                       irq_reg;

    logic [13:0]                  word_idx;
    logic                         lane0;
    logic                         wr_take;
    logic                         rd_load;
    logic                         wr_pattern;
    logic                         wr_control;
    logic                         wr_low;
    logic                         wr_high;
    logic                         wr_enable;
    logic                         wr_status;
    logic [7:0]                   wbyte;
    logic [7:0]                   rbyte;
    logic                         melody_run;
    logic [matg_pkg::DIV_W-1:0]   melody_divisor;
    logic                         melody_wave;
    logic [matg_pkg::FR_W-1:0]    fr_count;
    logic [RN-1:0]                rate_tick;
    logic                         fr_running;
    logic [2:0]                   alarm_slot;
    logic                         alarm_carrier;
    logic                         alarm_wave;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [13:0] idx,
                                 input logic [13:0] target);
        hit = (idx == target);
    endfunction

    // One wait state: read data are loaded first, then waitrequest drops
    assign word_idx        = avs_address[15:2];
    assign lane0           = avs_byteenable[0];
    assign wbyte           = avs_writedata[7:0];
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign wr_take         = avs_write & ack_reg & lane0;
    assign rd_load         = avs_read & ~ack_reg;
    assign wr_pattern = wr_take & hit(word_idx, matg_pkg::IDX_ALARM_PATTERN);
    assign wr_control = wr_take & hit(word_idx, matg_pkg::IDX_TONE_CONTROL);
    assign wr_low     = wr_take & hit(word_idx, matg_pkg::IDX_DIVISOR_LOW);
    assign wr_high    = wr_take & hit(word_idx, matg_pkg::IDX_DIVISOR_HIGH);
    assign wr_enable  = wr_take & hit(word_idx, matg_pkg::IDX_RATE_IRQ_EN);
    assign wr_status  = wr_take & hit(word_idx, matg_pkg::IDX_RATE_IRQ_STAT);

    // Read mux; counter control reads as zero, unmapped words read zero
    assign rbyte =
        hit(word_idx, matg_pkg::IDX_ALARM_PATTERN) ? alarm_pattern_reg :
        hit(word_idx, matg_pkg::IDX_TONE_CONTROL)  ?
            {2'h0, alarm_invert_reg, 4'h0, output_source_select_reg} :
        hit(word_idx, matg_pkg::IDX_DIVISOR_LOW)   ? melody_divisor_low_reg :
        hit(word_idx, matg_pkg::IDX_DIVISOR_HIGH)  ?
            {melody_divisor_high_reg[7], 3'h0, melody_divisor_high_reg[3:0]} :
        hit(word_idx, matg_pkg::IDX_RATE_IRQ_EN)   ?
            {3'h0, rate_interrupt_enable_reg} :
        hit(word_idx, matg_pkg::IDX_RATE_IRQ_STAT) ?
            {3'h0, rate_status_reg} : 8'h00;
    assign readdata_next = rd_load ? {24'h000000, rbyte} : readdata_reg;
    assign avs_readdata  = readdata_reg;

    // Handshake and read data
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ack_reg      <= 1'b0;
            readdata_reg <= 32'h00000000;
        end else begin
            ack_reg      <= (avs_read | avs_write) & ~ack_reg;
            readdata_reg <= readdata_next;
        end
    end

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            alarm_pattern_reg         <= matg_pkg::REG_RESET;
            output_source_select_reg  <= 1'b0;
            alarm_invert_reg          <= 1'b0;
            melody_divisor_low_reg    <= matg_pkg::REG_RESET;
            melody_divisor_high_reg   <= matg_pkg::REG_RESET;
            rate_interrupt_enable_reg <= '0;
        end else begin
            if (wr_pattern) begin
                alarm_pattern_reg <= wbyte;
            end
            if (wr_control) begin
                output_source_select_reg <= wbyte[matg_pkg::TC_SEL_BIT];
                alarm_invert_reg         <= wbyte[matg_pkg::TC_INV_BIT];
            end
            if (wr_low) begin
                melody_divisor_low_reg <= wbyte;
            end
            if (wr_high) begin
                melody_divisor_high_reg <= wbyte;
            end
            if (wr_enable) begin
                rate_interrupt_enable_reg <= wbyte[RN-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Low-speed tick: exact 32.768 kHz average from the 20 MHz clock
    // ------------------------------------------------------------------
    // Phase accumulation avoids the drift a plain integer divider has
    assign acc_sum = acc_reg + matg_pkg::LS_STEP;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            acc_reg     <= '0;
            ls_tick_reg <= 1'b0;
        end else if (acc_sum >= matg_pkg::LS_MOD) begin
            acc_reg     <= acc_sum - matg_pkg::LS_MOD;
            ls_tick_reg <= 1'b1;
        end else begin
            acc_reg     <= acc_sum;
            ls_tick_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Melody and free-run counter
    // ------------------------------------------------------------------
    assign melody_run     = melody_divisor_high_reg[matg_pkg::MH_RUN_BIT];
    assign melody_divisor = {melody_divisor_high_reg[3:0],
                             melody_divisor_low_reg};

    matg_melody u_melody (
        .core_clk (core_clk),
        .rst      (rst),
        .ls_tick  (ls_tick_reg),
        .run      (melody_run),
        .divisor  (melody_divisor),
        .wave_reg (melody_wave)
    );

    matg_freerun u_freerun (
        .core_clk      (core_clk),
        .rst           (rst),
        .ls_tick       (ls_tick_reg),
        .fc_write      (wr_control),
        .fc_code       (wbyte[matg_pkg::TC_FC_LSB +: 2]),
        .count_reg     (fr_count),
        .rate_tick_reg (rate_tick),
        .running       (fr_running)
    );

    // ------------------------------------------------------------------
    // Alarm waveform and output pin
    // ------------------------------------------------------------------
    // Eight slots per counter wrap, each gated onto the 4096 Hz carrier
    assign alarm_slot    = fr_count[matg_pkg::SLOT_LSB +: 3];
    assign alarm_carrier = fr_count[matg_pkg::CARRIER_BIT];
    assign alarm_wave    = (alarm_pattern_reg[alarm_slot] & alarm_carrier)
                           ^ alarm_invert_reg;

    // Registered mux keeps the pin glitch free when the select changes
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tone_reg <= 1'b0;
        end else begin
            tone_reg <= output_source_select_reg ? melody_wave
                                                 : alarm_wave;
        end
    end
    assign tone_output_pin = tone_reg;

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    // Set wins over a write-one clear in the same cycle
    assign rate_status_next = (rate_status_reg &
                               ~(wr_status ? wbyte[RN-1:0] : '0))
                              | rate_tick;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rate_status_reg <= '0;
            irq_reg         <= 1'b0;
        end else begin
            rate_status_reg <= rate_status_next;
            irq_reg <= |(rate_status_next
                         & rate_interrupt_enable_reg);
        end
    end
    assign irq = irq_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_pin_melody;
        @(posedge core_clk) disable iff (rst)
        $past(output_source_select_reg)
        |-> tone_output_pin == $past(melody_wave);
    endproperty
    a_pin_melody: assert property (p_pin_melody)
        else $error("pin does not follow melody");

    property p_pin_alarm;
        @(posedge core_clk) disable iff (rst)
        !$past(output_source_select_reg)
        |-> tone_output_pin == $past(alarm_wave);
    endproperty
    a_pin_alarm: assert property (p_pin_alarm)
        else $error("pin does not follow alarm");

    property p_tick_spacing;
        @(posedge core_clk) disable iff (rst)
        ls_tick_reg |=> !ls_tick_reg [*8];
    endproperty
    a_tick_spacing: assert property (p_tick_spacing)
        else $error("low-speed ticks too close");

    property p_high_divisor;
        @(posedge core_clk) disable iff (rst)
        wr_high |=> melody_divisor[11:8] == $past(wbyte[3:0]);
    endproperty
    a_high_divisor: assert property (p_high_divisor)
        else $error("upper divisor bits not stored");

    property p_melody_stop;
        @(posedge core_clk) disable iff (rst)
        !melody_run |=> !melody_wave;
    endproperty
    a_melody_stop: assert property (p_melody_stop)
        else $error("melody runs while stopped");

    property p_fc_clear;
        @(posedge core_clk) disable iff (rst)
        wr_control && wbyte[7] |=> fr_count == 15'h0000;
    endproperty
    a_fc_clear: assert property (p_fc_clear)
        else $error("counter not cleared");

    property p_fc_hold;
        @(posedge core_clk) disable iff (rst)
        wr_control && wbyte[7:6] == matg_pkg::FC_HOLD
        |=> $stable(fr_count) && !fr_running;
    endproperty
    a_fc_hold: assert property (p_fc_hold)
        else $error("counter moves while held");

    property p_second_wrap;
        @(posedge core_clk) disable iff (rst)
        rate_tick[4] |-> fr_count[1:0] == 2'h0
            && (!rate_tick[0] || fr_count == 15'h0000);
    endproperty
    a_second_wrap: assert property (p_second_wrap)
        else $error("rate tick off counter wrap");

    property p_melody_edge;
        @(posedge core_clk) disable iff (rst)
        melody_run && $past(melody_run) && $changed(melody_wave)
        |-> $past(ls_tick_reg);
    endproperty
    a_melody_edge: assert property (p_melody_edge)
        else $error("melody toggled without a tick");

    property p_irq_gate;
        @(posedge core_clk) disable iff (rst)
        |(rate_tick & rate_interrupt_enable_reg) |=> irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("enabled tick raised no request");

    property p_status_sticky;
        @(posedge core_clk) disable iff (rst)
        rate_tick[4] |=> rate_status_reg[4];
    endproperty
    a_status_sticky: assert property (p_status_sticky)
        else $error("8192 Hz tick lost");

    c_melody_toggle: cover property (@(posedge core_clk) disable iff (rst)
        melody_run && $rose(melody_wave));
    c_irq_rise: cover property (@(posedge core_clk) disable iff (rst)
        $rose(irq));
    c_clear_start: cover property (@(posedge core_clk) disable iff (rst)
        wr_control && wbyte[7:6] == matg_pkg::FC_CLEAR_START);
    c_alarm_pin: cover property (@(posedge core_clk) disable iff (rst)
        !output_source_select_reg && $rose(tone_output_pin));

endmodule

// ==== verification/matg_speaker.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Loudspeaker on the tone pin: measures half periods in clocks
// ------------------------------------------------------------------
module matg_speaker (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic tone,
    output int        half_len,
    output int        edges
);
    int   run_len;
    logic last;
    // A speaker only listens, so it never drives anything back
    always @(posedge core_clk) begin
        if (rst) begin
            run_len <= 0;
            half_len <= 0;
            edges <= 0;
            last <= 1'b0;
        end else if (tone !== last) begin
            half_len <= run_len + 1;
            run_len <= 0;
            edges <= edges + 1;
            last <= tone;
        end else begin
            run_len <= run_len + 1;
        end
    end
endmodule

// ==== verification/tb_melody_alarm_tone_generator.sv ====
`timescale 1ns/1ps
module tb_melody_alarm_tone_generator;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] avs_address = 16'h0000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        tone_output_pin;
    logic        irq;
    int          half_len;
    int          edges;
    int          mismatches = 0;
    int          tests_run = 0;
    int          seed = 35;
    logic [7:0]  rd;
    logic [7:0]  v;
    logic [13:0] idx_tab [4] = '{14'h1330, 14'h1332, 14'h1333, 14'h1334};
    logic [7:0]  msk_tab [4] = '{8'hFF, 8'hFF, 8'h8F, 8'h1F};
    int          div_tab [2] = '{1, 20};

    always #25 core_clk = ~core_clk;

    matg_top u_dut (.core_clk(core_clk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .tone_output_pin(tone_output_pin), .irq(irq));
    matg_speaker u_spk (.core_clk(core_clk), .rst(rst),
        .tone(tone_output_pin), .half_len(half_len), .edges(edges));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic close_out();
        $display("mismatches %0d of tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One Avalon access; an edge always passes before a new request
    task automatic xfer(input logic wr, input logic [13:0] idx,
                        input logic [7:0] wd, input logic [3:0] be);
        @(posedge core_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h000000, wd};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    // Expected clocks in a span of low-speed ticks
    function automatic int tick_clk(input int ticks);
        return ticks * matg_pkg::CLK_HZ / matg_pkg::LS_HZ;
    endfunction

    task automatic check_half(input int ticks);
        int start;
        start = edges;
        for (int n = 0; n < 40000 && edges < start + 2; n++)
            @(posedge core_clk);
        check(32'(half_len >= tick_clk(ticks) - 3 &&
                  half_len <= tick_clk(ticks) + 3), 32'h1);
    endtask

    // A hang ends the run through the same closing task
    initial begin
        repeat (90000) @(posedge core_clk);
        mismatches++;
        close_out();
    end

    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        // Reset values, then random write and read-back
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, 14'h1330 + 14'(i), 8'h00, 4'hF);
            check(rd, 8'h00);
        end
        for (int k = 0; k < 8; k++) begin
            v = 8'($random(seed));
            xfer(1'b1, idx_tab[k%4], v, 4'hF);
            xfer(1'b0, idx_tab[k%4], 8'h00, 4'hF);
            check(rd, v & msk_tab[k%4]);
        end
        v = 8'($random(seed));
        xfer(1'b1, 14'h1331, v, 4'hF);
        xfer(1'b0, 14'h1331, 8'h00, 4'hF);
        check(rd, v & 8'h21);
        // Lane 0 disabled drops the write; unmapped word reads zero
        xfer(1'b1, 14'h1330, 8'hA5, 4'hF);
        xfer(1'b1, 14'h1330, 8'h5A, 4'h0);
        xfer(1'b0, 14'h1330, 8'h00, 4'hF);
        check(rd, 8'hA5);
        xfer(1'b0, 14'h1336, 8'h00, 4'hF);
        check(rd, 8'h00);
        // Melody half period is divisor plus two ticks
        xfer(1'b1, 14'h1331, 8'h01, 4'hF);
        for (int i = 0; i < 2; i++) begin
            xfer(1'b1, 14'h1333, 8'h00, 4'hF);
            repeat (3) @(posedge core_clk);
            check(tone_output_pin, 1'b0);
            xfer(1'b1, 14'h1332, 8'(div_tab[i]), 4'hF);
            xfer(1'b1, 14'h1333, 8'h80, 4'hF);
            check_half(div_tab[i] + 2);
        end
        // Alarm: select, clear, pattern, run; carrier toggles per 4 ticks
        xfer(1'b1, 14'h1331, 8'h80, 4'hF);
        xfer(1'b1, 14'h1330, 8'hFF, 4'hF);
        xfer(1'b1, 14'h1331, 8'h40, 4'hF);
        check_half(4);
        // Clear and start from a held zero count
        xfer(1'b1, 14'h1331, 8'h80, 4'hF);
        xfer(1'b1, 14'h1331, 8'hC0, 4'hF);
        check_half(4);
        xfer(1'b1, 14'h1330, 8'h00, 4'hF);
        xfer(1'b1, 14'h1331, 8'h60, 4'hF);
        repeat (3) @(posedge core_clk);
        check(tone_output_pin, 1'b1);
        xfer(1'b1, 14'h1331, 8'h40, 4'hF);
        repeat (3) @(posedge core_clk);
        check(tone_output_pin, 1'b0);
        // Interrupt: masked, then enabled, then cleared
        xfer(1'b1, 14'h1334, 8'h00, 4'hF);
        xfer(1'b1, 14'h1335, 8'h1F, 4'hF);
        v = 8'h00;
        repeat (3000) begin
            @(posedge core_clk);
            v = v | 8'(irq);
        end
        check(v, 8'h00);
        xfer(1'b0, 14'h1335, 8'h00, 4'hF);
        check(rd & 8'h10, 8'h10);
        xfer(1'b1, 14'h1334, 8'h10, 4'hF);
        repeat (2) @(posedge core_clk);
        check(irq, 1'b1);
        // Let an enabled tick pass, hold the counter, then clear by W1C
        repeat (2500) @(posedge core_clk);
        xfer(1'b1, 14'h1331, 8'h00, 4'hF);
        xfer(1'b1, 14'h1335, 8'h1F, 4'hF);
        @(posedge core_clk);
        check(irq, 1'b0);
        xfer(1'b0, 14'h1335, 8'h00, 4'hF);
        check(rd, 8'h00);
        close_out();
    end
endmodule
